// [iuv_defines.svh]
// Constants of the input undervoltage fault register bank.
// Included by the package and the design modules by bare name.
`ifndef IUV_DEFINES_SVH
`define IUV_DEFINES_SVH
// Command codes and page
`define IUV_CMD_THRESHOLD 8'h59
`define IUV_CMD_ACTION 8'h5a
`define IUV_PAGE_ONLY 8'h00
// Reset values
`define IUV_THRESHOLD_RST 16'h02d0
`define IUV_ACTION_RST 8'hbc
// Action field positions
`define IUV_BEHAV_HI 7
`define IUV_BEHAV_LO 6
`define IUV_RETRY_HI 5
`define IUV_RETRY_LO 3
`define IUV_DELAY_HI 2
`define IUV_DELAY_LO 0
// Field codes
`define IUV_BEHAV_CONTINUE 2'b00
`define IUV_BEHAV_DISABLE 2'b10
`define IUV_RETRY_NONE 3'b000
`define IUV_RETRY_FOREVER 3'b111
`define IUV_DELAY_MAX_CODE 3'b111
// Timing: 25 ms per delay step, 175 ms for the top code, 8 ns clock
`define IUV_CLK_NS 8
`define IUV_DELAY_STEP_MS 25
`define IUV_DELAY_TOP_MS 175
`define IUV_MS_CYCLES (1000000 / `IUV_CLK_NS)
`endif

// [iuv_pkg.sv]
// Types of the input undervoltage fault register bank.
// Needs iuv_defines.svh on the include path.
`include "iuv_defines.svh"
package iuv_pkg;
   typedef enum {IUV_RUN, IUV_FAULT_OFF, IUV_WAIT, IUV_LATCHED} iuv_state_e;
   typedef logic [15:0] iuv_word_t;
endpackage : iuv_pkg

// [iuv_tick.sv]
// Millisecond enable divider for the retry delay.
// Runs on the single management clock.
`timescale 1ns/10ps
`include "iuv_defines.svh"
module iuv_tick #(
   parameter int CYCLES_PER_MS = `IUV_MS_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Enable pulse
   output logic ms_tick
);
   initial begin
      if (CYCLES_PER_MS < 1) $error("CYCLES_PER_MS must be at least 1");
   end
   logic [31:0] cnt_q, cnt_d;
   logic tick_q, tick_d;
   // Count down one millisecond
   always_comb begin
      tick_d = (cnt_q == 32'h0);
      cnt_d = tick_d ? 32'(CYCLES_PER_MS - 1) : cnt_q - 32'h1;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign ms_tick = tick_q;
endmodule : iuv_tick

// [iuv_regs.sv]
// Input undervoltage fault threshold and action registers with response logic.
// Command writes/reads arrive already decoded from the management bus engine.
// How it works
// R01 - Threshold LSB weighs 10 mV of input voltage.
// R02 - Threshold is signed two's complement, -327680 to 327670 mV.
// R03 - Threshold is a two-byte read/write command; mV equals raw times ten.
// R04 - Threshold resets to 02D0h, that is 7200 mV.
// R05 - Both commands are paged; only page 00h is accepted.
// R06 - Host should set threshold to zero when using turn-on/off levels.
// R07 - Fault clears only once input exceeds threshold plus one sixteenth.
// R08 - Action register is a one-byte read/write bit field.
// R09 - Action resets to BCh, disable and retry.
// R10 - Bits 7:6: 00 continue, 10 disable and retry; alert and status set.
// R11 - Bits 5:3: 000 stay off until restart, 111 retry without limit.
// R12 - Bits 2:0: 0 ms, 25 ms per step, or 175 ms retry delay.
// R13 - Fault declared when input falls below threshold; response applied.
`timescale 1ns/10ps
`include "iuv_defines.svh"
module iuv_regs
   import iuv_pkg::*;
#(
   parameter int CYCLES_PER_MS = `IUV_MS_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Decoded command access
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_page,
   input wire logic [15:0] cmd_wdata,
   output logic [15:0] cmd_rdata,
   output logic cmd_ack,
   output logic cmd_nack,
   // Input voltage sample in 10 mV units, signed
   input wire logic signed [15:0] vin_meas,
   // Restart, off and status clear requests
   input wire logic restart,
   input wire logic cmd_off,
   input wire logic status_clear,
   // Fault outputs
   output logic uv_fault,
   output logic output_enable,
   output logic alert_out_n,
   output logic status_uv
);
   initial begin
      if (CYCLES_PER_MS < 1) $error("CYCLES_PER_MS must be at least 1");
   end
   logic ms_tick;
   iuv_tick #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick (
      .clk(clk),
      .rst(rst),
      .ms_tick(ms_tick)
   );

   // Delay in ms for a delay code
   function automatic logic [7:0] delay_ms(input logic [2:0] code);
      if (code == `IUV_DELAY_MAX_CODE) delay_ms = 8'(`IUV_DELAY_TOP_MS); // [R12]
      else delay_ms = 8'(code * `IUV_DELAY_STEP_MS); // [R12]
   endfunction : delay_ms

   // Command accepted only on the single page
   function automatic logic hit(input logic [7:0] code, input logic [7:0] page,
                                input logic [7:0] want);
      hit = (code == want) && (page == `IUV_PAGE_ONLY); // [R05]
   endfunction : hit

   logic signed [15:0] thr_q, thr_d;
   logic [7:0] act_q, act_d;
   logic [15:0] rdata_q, rdata_d;
   logic ack_q, ack_d, nack_q, nack_d;
   // Register file writes and reads
   always_comb begin
      thr_d = thr_q;
      act_d = act_q;
      rdata_d = rdata_q;
      ack_d = 1'b0;
      nack_d = 1'b0;
      if (cmd_wr || cmd_rd) begin
         if (hit(cmd_code, cmd_page, `IUV_CMD_THRESHOLD)) begin
            ack_d = 1'b1;
            if (cmd_wr) thr_d = cmd_wdata; // [R03] [R02]
            else rdata_d = thr_q;
         end else if (hit(cmd_code, cmd_page, `IUV_CMD_ACTION)) begin
            ack_d = 1'b1;
            if (cmd_wr) act_d = cmd_wdata[7:0]; // [R08]
            else rdata_d = {8'h00, act_q};
         end else begin
            nack_d = 1'b1; // [R05]
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         thr_q <= `IUV_THRESHOLD_RST; // [R04]
         act_q <= `IUV_ACTION_RST; // [R09]
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         thr_q <= thr_d;
         act_q <= act_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         nack_q <= nack_d;
      end
   end

   // Trip and clear levels, both in 10 mV units; 17-bit to avoid overflow
   logic signed [16:0] clear_lvl;
   logic below, above_clear;
   assign clear_lvl = 17'(thr_q) + 17'(thr_q >>> 4); // [R07]
   assign below = vin_meas < thr_q; // [R13] [R01]
   assign above_clear = 17'(vin_meas) > clear_lvl; // [R07]

   logic [1:0] behav;
   logic [2:0] retry;
   assign behav = act_q[`IUV_BEHAV_HI:`IUV_BEHAV_LO];
   assign retry = act_q[`IUV_RETRY_HI:`IUV_RETRY_LO];

   iuv_state_e st_q, st_d;
   logic fault_q, fault_d, en_q, en_d, alert_q, alert_d, stat_q, stat_d;
   logic [7:0] wait_q, wait_d;
   // Fault detection and response sequencing
   always_comb begin
      st_d = st_q;
      wait_d = wait_q;
      fault_d = fault_q;
      if (!fault_q && below) fault_d = 1'b1; // [R13]
      else if (fault_q && above_clear) fault_d = 1'b0; // [R07]
      // Status set wins over clear
      stat_d = (below && !fault_q) ? 1'b1 : (status_clear ? 1'b0 : stat_q); // [R10]
      alert_d = !stat_d; // [R10]
      case (st_q)
         IUV_RUN: begin
            if (below && behav == `IUV_BEHAV_DISABLE) st_d = IUV_FAULT_OFF; // [R10]
         end
         IUV_FAULT_OFF: begin
            if (retry == `IUV_RETRY_FOREVER) begin // [R11]
               st_d = IUV_WAIT;
               wait_d = delay_ms(act_q[`IUV_DELAY_HI:`IUV_DELAY_LO]); // [R12]
            end else st_d = IUV_LATCHED; // [R11]
         end
         IUV_WAIT: begin
            if (cmd_off) st_d = IUV_LATCHED; // [R11]
            else if (wait_q == 8'h00 && !fault_d) st_d = IUV_RUN; // [R11]
            else if (ms_tick && wait_q != 8'h00) wait_d = wait_q - 8'h01; // [R12]
         end
         IUV_LATCHED: begin
            if (restart) st_d = IUV_RUN; // [R11]
         end
         default: st_d = IUV_RUN;
      endcase
      en_d = (st_d == IUV_RUN);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= IUV_RUN;
         wait_q <= 8'h00;
         fault_q <= 1'b0;
         en_q <= 1'b1;
         alert_q <= 1'b1;
         stat_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wait_q <= wait_d;
         fault_q <= fault_d;
         en_q <= en_d;
         alert_q <= alert_d;
         stat_q <= stat_d;
      end
   end

   assign cmd_rdata = rdata_q;
   assign cmd_ack = ack_q;
   assign cmd_nack = nack_q;
   assign uv_fault = fault_q;
   assign output_enable = en_q;
   assign alert_out_n = alert_q;
   assign status_uv = stat_q;

   // Checks
   property p_thr_write;
      @(posedge clk) disable iff (rst)
      (cmd_wr && hit(cmd_code, cmd_page, `IUV_CMD_THRESHOLD)) |=> (thr_q == $past(cmd_wdata));
   endproperty
   a_thr_write: assert property (p_thr_write) else $error("threshold write lost"); // [R03]
   property p_bad_page;
      @(posedge clk) disable iff (rst)
      ((cmd_wr || cmd_rd) && cmd_page != `IUV_PAGE_ONLY) |=> (cmd_nack && $stable(thr_q));
   endproperty
   a_bad_page: assert property (p_bad_page) else $error("wrong page accepted"); // [R05]
   property p_reset_vals;
      @(posedge clk) rst |=> (thr_q == `IUV_THRESHOLD_RST && act_q == `IUV_ACTION_RST);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // [R04]
   property p_trip;
      @(posedge clk) disable iff (rst) (!fault_q && below) |=> (fault_q && !alert_out_n);
   endproperty
   a_trip: assert property (p_trip) else $error("fault not declared"); // [R13]
   property p_hold;
      @(posedge clk) disable iff (rst) (fault_q && !above_clear) |=> fault_q;
   endproperty
   a_hold: assert property (p_hold) else $error("fault cleared early"); // [R07]
   property p_disable;
      @(posedge clk) disable iff (rst)
      (st_q == IUV_RUN && below && behav == `IUV_BEHAV_DISABLE) |=> ##1 !output_enable;
   endproperty
   a_disable: assert property (p_disable) else $error("output not disabled"); // [R10]
   property p_continue;
      @(posedge clk) disable iff (rst)
      (st_q == IUV_RUN && behav == `IUV_BEHAV_CONTINUE) |=> st_q == IUV_RUN;
   endproperty
   a_continue: assert property (p_continue) else $error("continue mode stopped"); // [R10]
   property p_latch;
      @(posedge clk) disable iff (rst)
      (st_q == IUV_FAULT_OFF && retry == `IUV_RETRY_NONE) |=> st_q == IUV_LATCHED;
   endproperty
   a_latch: assert property (p_latch) else $error("no-retry did not latch"); // [R11]
   property p_delay_load;
      @(posedge clk) disable iff (rst)
      (st_q == IUV_FAULT_OFF && retry == `IUV_RETRY_FOREVER && act_q[2:0] == 3'b111)
      |=> wait_q == 8'd175;
   endproperty
   a_delay_load: assert property (p_delay_load) else $error("retry delay wrong"); // [R12]
endmodule : iuv_regs

// [iuv_host.sv]
// Host model that issues decoded register commands to the bank.
// Assumes one management clock; changes its outputs 1 ns after a rising edge.
`timescale 1ns/10ps
module iuv_host (
   // Clock
   input wire logic clk,
   // Command side
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_page,
   output logic [15:0] cmd_wdata,
   // Answer side
   input wire logic [15:0] cmd_rdata,
   input wire logic cmd_ack,
   input wire logic cmd_nack
);
   // Idle values
   initial begin
      cmd_wr = 1'h0;
      cmd_rd = 1'h0;
      cmd_code = 8'h00;
      cmd_page = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One-cycle strobe, answer taken in the following cycle
   task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
         input logic [15:0] d, output logic [17:0] r);
      @(posedge clk);
      #1;
      cmd_wr = w;
      cmd_rd = !w;
      cmd_code = c;
      cmd_page = p;
      cmd_wdata = d;
      @(posedge clk);
      #1;
      cmd_wr = 1'h0;
      cmd_rd = 1'h0;
      cmd_wdata = ~d;
      r = {cmd_ack, cmd_nack, cmd_rdata};
   endtask : xfer
endmodule : iuv_host

// [iuv_regs_tb.sv]
// Self-checking bench for the undervoltage fault register bank.
// Uses iuv_host as command source; the ms divider is shortened to 4 cycles.
`timescale 1ns/10ps
`include "iuv_defines.svh"
module iuv_regs_tb;
   import iuv_pkg::*;
   localparam int CPM = 4;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic cmd_wr;
   logic cmd_rd;
   logic [7:0] cmd_code;
   logic [7:0] cmd_page;
   logic [15:0] cmd_wdata;
   logic [15:0] cmd_rdata;
   logic cmd_ack;
   logic cmd_nack;
   logic signed [15:0] vin_meas = 16'h0400;
   logic restart = 1'h0;
   logic cmd_off = 1'h0;
   logic status_clear = 1'h0;
   logic uv_fault;
   logic output_enable;
   logic alert_out_n;
   logic status_uv;
   logic [17:0] r;
   logic [7:0] act [3] = '{8'hb8, 8'hb9, 8'hbf};
   int ms [3] = '{0, 25, 175};
   int failures = 0;
   int n_compared = 0;

   // Clock
   always #4 clk = ~clk;

   iuv_host iuv_host_inst (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata),
      .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack));
   iuv_regs #(.CYCLES_PER_MS(CPM)) iuv_regs_inst (.clk(clk), .rst(rst),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_page(cmd_page),
      .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
      .cmd_nack(cmd_nack), .vin_meas(vin_meas), .restart(restart), .cmd_off(cmd_off),
      .status_clear(status_clear), .uv_fault(uv_fault), .output_enable(output_enable),
      .alert_out_n(alert_out_n), .status_uv(status_uv));

   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Write; only ack and nack are compared
   task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
         input logic [1:0] e);
      iuv_host_inst.xfer(1'h1, c, p, d, r);
      chk("write", {e, 16'h0000}, {r[17:16], 16'h0000});
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] d);
      iuv_host_inst.xfer(1'h0, c, 8'h00, 16'h0000, r);
      chk("read", {2'h2, d}, r);
   endtask : rd

   // Fault, enable, alert, status
   task automatic pins(input logic [3:0] e);
      chk("pins", {14'h0000, e}, {14'h0000, uv_fault, output_enable, alert_out_n, status_uv});
   endtask : pins

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_n

   task automatic pulse(ref logic s);
      s = 1'h1;
      wait_n(1);
      s = 1'h0;
      wait_n(3);
   endtask : pulse

   task automatic finish_test;
      $display("Counts: %0d compared, %0d failures", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test

   // Watchdog
   initial begin
      #40000;
      failures++;
      finish_test();
   end

   // Test sequence
   initial begin
      wait_n(8);
      rst = 1'h0;
      pins(4'h6);
      rd(`IUV_CMD_THRESHOLD, 16'h02d0);
      rd(`IUV_CMD_ACTION, 16'h00bc);
      wr(`IUV_CMD_THRESHOLD, 8'h01, 16'h1234, 2'h1);
      wr(8'h5b, 8'h00, 16'h1234, 2'h1);
      rd(`IUV_CMD_THRESHOLD, 16'h02d0);
      wr(`IUV_CMD_THRESHOLD, 8'h00, 16'h8000, 2'h2);
      rd(`IUV_CMD_THRESHOLD, 16'h8000);
      wr(`IUV_CMD_ACTION, 8'h00, 16'hff80, 2'h2);
      rd(`IUV_CMD_ACTION, 16'h0080);
      wr(`IUV_CMD_THRESHOLD, 8'h00, 16'h0100, 2'h2);
      vin_meas = 16'h0100;
      wait_n(3);
      pins(4'h6);
      vin_meas = 16'h00ff;
      wait_n(2);
      pins(4'h9);
      vin_meas = 16'h0110;
      wait_n(3);
      pins(4'h9);
      vin_meas = 16'h0111;
      wait_n(3);
      pins(4'h1);
      pulse(restart);
      pins(4'h5);
      pulse(status_clear);
      pins(4'h6);
      wr(`IUV_CMD_ACTION, 8'h00, 16'h0000, 2'h2);
      vin_meas = 16'h00ff;
      wait_n(3);
      pins(4'hd);
      vin_meas = 16'h0200;
      wait_n(3);
      pulse(status_clear);
      for (int i = 0; i < 3; i++) begin
         wr(`IUV_CMD_ACTION, 8'h00, {8'h00, act[i]}, 2'h2);
         vin_meas = 16'h00ff;
         wait_n(2);
         vin_meas = 16'h0200;
         if (ms[i] > 0) begin
            wait_n(ms[i] * CPM - 8);
            chk("enable", 18'h00000, {17'h00000, output_enable});
         end
         wait_n(16);
         pins(4'h5);
      end
      vin_meas = 16'h00ff;
      wait_n(2);
      vin_meas = 16'h0200;
      pulse(cmd_off);
      wait_n(800);
      pins(4'h1);
      pulse(restart);
      pins(4'h5);
      wr(`IUV_CMD_THRESHOLD, 8'h00, 16'h0000, 2'h2);
      rd(`IUV_CMD_THRESHOLD, 16'h0000);
      finish_test();
   end
endmodule : iuv_regs_tb
